// ==== verilog/fram_pkg.sv ====
// Shared constants and types for the two-wire memory slave.
// Assumes bus pins are sampled by the one system clock.
package fram_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int DEPTH = 65536;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 1;
	localparam int RW_BIT = 0;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Arbitrary device-type code
	localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_ACK_DEV,
		ST_ADDR_HI,
		ST_ACK_HI,
		ST_ADDR_LO,
		ST_ACK_LO,
		ST_WDATA,
		ST_ACK_W,
		ST_RDATA,
		ST_RACK
	} proto_state_t;
endpackage

// ==== verilog/fram_mem_if.sv ====
// Carrier between the protocol engine and the storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fram_mem_if;
	import fram_pkg::*;
	logic [ADDR_W-1:0] raddr;
	logic [ADDR_W-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic we;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output raddr, output waddr, output wdata, output we, input rdata);
	modport array (input raddr, input waddr, input wdata, input we, output rdata);
endinterface

// ==== verilog/fram_array.sv ====
// Byte-wide flip-flop storage with registered read.
// Assumes write strobes are one-cycle pulses from the engine.
`timescale 1ns/1ps
module fram_array
	import fram_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Engine side
	fram_mem_if.array mem
);
	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] cells;
		logic [DATA_W-1:0] rdata;
	} array_state_t;

	array_state_t q;
	array_state_t d;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_comb begin
		d = q;
		// Full-width index, every address its own cell
		if (mem.we) begin
			d.cells[mem.waddr] = mem.wdata;
		end
		d.rdata = q.cells[mem.raddr];
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign mem.rdata = q.rdata;
endmodule

// ==== verilog/fram_slave.sv ====
// Two-wire slave protocol engine in front of the byte array.
// Assumes bus pins are already synchronous to i_clk.
`timescale 1ns/1ps
module fram_slave
	import fram_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Straps
	input wire logic [2:0] i_device_select_inputs,
	input wire logic i_write_protect,
	// Status
	output logic o_selected
);
	typedef struct packed {
		logic scl;
		logic sda;
		proto_state_t state;
		logic [3:0] cnt;
		logic [DATA_W-1:0] shift;
		logic [ADDR_W-1:0] addr;
		logic rw;
		logic ack_pend;
		logic sda_oe_n;
		logic sda_o;
		logic we;
		logic [ADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wdata;
		logic selected;
	} slave_state_t;

	slave_state_t q;
	slave_state_t d;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic [DATA_W-1:0] byte_in;
	logic dev_hit;

	fram_mem_if mem ();

	fram_array u_array (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.mem(mem)
	);

	// ----------------------------------------
	// Bus events
	// ----------------------------------------
	// Edges come only from the sampled bus lines
	assign rise = !q.scl && i_scl;
	assign fall = q.scl && !i_scl;
	assign start_c = q.scl && i_scl && q.sda && !i_sda;
	assign stop_c = q.scl && i_scl && !q.sda && i_sda;
	assign byte_in = {q.shift[DATA_W-2:0], i_sda};
	// Type and select fields of the slave address
	assign dev_hit = byte_in[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE &&
		byte_in[SEL_MSB:SEL_LSB] == i_device_select_inputs;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	always_comb begin
		d = q;
		d.scl = i_scl;
		d.sda = i_sda;
		d.we = 1'b0;
		if (start_c) begin
			// Abort anything and await a slave address
			d.state = ST_DEV;
			d.cnt = 4'h0;
			d.ack_pend = 1'b0;
			d.sda_oe_n = 1'b1;
			d.selected = 1'b0;
		end else if (stop_c) begin
			d.state = ST_IDLE;
			d.ack_pend = 1'b0;
			d.sda_oe_n = 1'b1;
			d.selected = 1'b0;
		end else begin
			case (q.state)
			ST_DEV, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: begin
				if (rise) begin
					// Sample on the rising clock, MSB first
					d.shift = byte_in;
					d.cnt = q.cnt + 4'h1;
					if (q.cnt == LAST_BIT) begin
						d.ack_pend = 1'b1;
						d.cnt = 4'h0;
						case (q.state)
						ST_DEV: begin
							// Type, select, direction fields
							// Unconnected straps arrive as zero
							if (dev_hit) begin
								d.rw = byte_in[RW_BIT];
								d.selected = 1'b1;
								d.state = ST_ACK_DEV;
							end else begin
								d.ack_pend = 1'b0;
								d.state = ST_IDLE;
							end
						end
						ST_ADDR_HI: begin
							d.addr[ADDR_W-1:DATA_W] = byte_in;
							d.state = ST_ACK_HI;
						end
						ST_ADDR_LO: begin
							d.addr[DATA_W-1:0] = byte_in;
							d.state = ST_ACK_LO;
						end
						default: begin
							// Single-cycle store, ack still pending
							// Protect high blocks, low allows
							d.we = !i_write_protect;
							d.waddr = q.addr;
							d.wdata = byte_in;
							d.addr = q.addr + ADDR_ONE;
							d.state = ST_ACK_W;
						end
						endcase
					end
				end
			end
			ST_ACK_DEV, ST_ACK_HI, ST_ACK_LO, ST_ACK_W: begin
				if (fall) begin
					if (q.ack_pend) begin
						// Pull low to acknowledge, protected or not
						d.sda_oe_n = 1'b0;
						d.ack_pend = 1'b0;
					end else begin
						d.sda_oe_n = 1'b1;
						d.cnt = 4'h0;
						case (q.state)
						ST_ACK_DEV: d.state = q.rw ? ST_RDATA : ST_ADDR_HI;
						ST_ACK_HI: d.state = ST_ADDR_LO;
						default: d.state = ST_WDATA;
						endcase
					end
				end
			end
			ST_RDATA: begin
				if (fall && q.cnt != 4'h0) begin
					if (q.cnt == BYTE_BITS) begin
						d.sda_oe_n = 1'b1;
						d.state = ST_RACK;
					end else begin
						// Change output on the falling clock
						d.sda_oe_n = q.shift[DATA_W-1];
						d.shift = {q.shift[DATA_W-2:0], 1'b0};
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			ST_RACK: begin
				if (rise) begin
					// Ack asks for the next byte, nack ends
					d.cnt = 4'h0;
					d.state = i_sda ? ST_IDLE : ST_RDATA;
					d.selected = !i_sda;
				end
			end
			ST_IDLE: begin
				// Unaddressed: stay off the wire until the next start
				d.sda_oe_n = 1'b1;
			end
			default: begin
				d.sda_oe_n = 1'b1;
			end
			endcase
			if (fall && d.state == ST_RDATA && d.cnt == 4'h0) begin
				// Load byte, bump address before the ack
				d.sda_oe_n = mem.rdata[DATA_W-1];
				d.shift = {mem.rdata[DATA_W-2:0], 1'b0};
				d.addr = q.addr + ADDR_ONE;
				d.cnt = 4'h1;
			end
		end
		// Output data is a constant low; only the enable moves
		d.sda_o = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// Bus history resets to idle high so release cannot fake a stop or a rising clock
			q <= '{
				scl: 1'b1,
				sda: 1'b1,
				state: ST_IDLE,
				cnt: 4'h0,
				shift: DATA_RST,
				addr: ADDR_RST,
				rw: 1'b0,
				ack_pend: 1'b0,
				sda_oe_n: 1'b1,
				sda_o: 1'b0,
				we: 1'b0,
				waddr: ADDR_RST,
				wdata: DATA_RST,
				selected: 1'b0
			};
		end else if (i_ce) begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Reading at q.addr keeps rdata settled long before the next load
	assign mem.raddr = q.addr;
	assign mem.waddr = q.waddr;
	assign mem.wdata = q.wdata;
	assign mem.we = q.we;
	assign o_sda = q.sda_o;
	assign o_sda_oe_n = q.sda_oe_n;
	assign o_selected = q.selected;
endmodule

// ==== test/fram_slave_asserts.sv ====
// Pin checker for the two-wire memory slave.
// Assumes bus levels are sampled by the same clock as the design.
`timescale 1ns/1ps
module fram_slave_asserts(
	input logic i_clk,
	input logic i_reset_n,
	input logic i_scl,
	input logic i_sda,
	input logic o_sda,
	input logic o_sda_oe_n,
	input logic o_selected
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// ----
	// Pin relations
	// ----
	a_drive_only_low: assert property (o_sda == 1'b0) else $error("data driven high");
	a_change_on_fall: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
		else $error("data moved outside clock low");
	a_hold_clock_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
		else $error("data moved while clock high");
	a_drive_stands: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n[*2])
		else $error("low drive too short");
	// Ack only follows at the next bus clock fall
	a_select_on_ack: assert property ($rose(o_selected) |-> ##[1:8] !o_sda_oe_n)
		else $error("selected without ack");
	a_start_aborts: assert property (i_scl && $past(i_scl) && $past(i_sda) && !i_sda
		|-> ##[1:2] (!o_selected && o_sda_oe_n)) else $error("start did not abort");
	a_stop_frees: assert property (i_scl && $past(i_scl) && !$past(i_sda) && i_sda
		|-> ##[1:2] (!o_selected && o_sda_oe_n)) else $error("stop did not release");
	a_quiet_after_reset: assert property ($rose(i_reset_n) |-> o_sda_oe_n && !o_selected)
		else $error("busy after reset");
endmodule
bind fram_slave fram_slave_asserts u_fram_slave_asserts(.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_selected(o_selected));

// ==== test/fram_bus_master.sv ====
// Two-wire bus master model: drives the clock, open-drain data.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module fram_bus_master(
	input logic i_clk,
	input logic i_sda,
	output logic o_scl = 1'b1,
	output logic o_sda = 1'b1
);
	// ----
	// Bus phases, three clocks each to beat the two-clock minimum
	// ----
	task automatic ph(input logic c, input logic d);
		o_scl <= c;
		o_sda <= d;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic start();
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	endtask
	task automatic stop();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	// A high bit releases the wire, so reads send all ones
	task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			ph(1'b0, w[i]);
			ph(1'b1, w[i]);
			r[i] = i_sda;
		end
		ph(1'b0, m);
		ph(1'b1, m);
		a = i_sda;
	endtask
endmodule

// ==== test/serial_fram_slave_access_tb_top.sv ====
// Bench for the two-wire memory slave with a master model.
// Assumes a pull-up on the data wire; clock enable held high.
`timescale 1ns/1ps
module serial_fram_slave_access_tb_top;
	import fram_pkg::*;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0] d;
		logic [2:0] s;
		logic w;
		logic [7:0] e;
	} row_t;
	logic i_clk = 0;
	logic i_reset_n = 0;
	logic m_scl, m_sda, o_sda, o_sda_oe_n, o_selected, ack;
	logic wp = 0;
	logic [2:0] sel = 0;
	logic [7:0] r;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	wire bus_sda = m_sda & (o_sda_oe_n | o_sda);
	row_t rows [5] = '{{16'h0000, 8'ha5, 3'h0, 1'b0, 8'ha5}, {16'hffff, 8'h81, 3'h7, 1'b0, 8'h81},
		{16'h1234, 8'h3c, 3'h2, 1'b0, 8'h3c}, {16'h9234, 8'h77, 3'h3, 1'b0, 8'h77},
		{16'h1234, 8'hff, 3'h5, 1'b1, 8'h3c}};
	fram_slave u_fram_slave(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1), .i_scl(m_scl),
		.i_sda(bus_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_device_select_inputs(sel),
		.i_write_protect(wp), .o_selected(o_selected));
	fram_bus_master u_fram_bus_master(.i_clk(i_clk), .i_sda(bus_sda), .o_scl(m_scl), .o_sda(m_sda));
	initial forever #10 i_clk = ~i_clk;
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tx(input logic [7:0] b, input logic m);
		u_fram_bus_master.xfer(b, m, r, ack);
	endtask
	task automatic seta(input logic [15:0] a, input logic [2:0] s);
		u_fram_bus_master.start();
		tx({DEV_TYPE_CODE, s, 1'b0}, 1'b1);
		chk({7'h0, ack}, 8'h00);
		chk({7'h0, o_selected}, 8'h01);
		tx(a[15:8], 1'b1);
		tx(a[7:0], 1'b1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [2:0] s, input logic [7:0] e);
		seta(a, s);
		u_fram_bus_master.start();
		tx({DEV_TYPE_CODE, s, 1'b1}, 1'b1);
		tx(8'hff, 1'b1);
		u_fram_bus_master.stop();
		chk(r, e);
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	// ----
	// Sequence
	// ----
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk({6'h0, o_sda_oe_n, o_selected}, 8'h02);
		foreach (rows[i]) begin
			sel <= rows[i].s;
			wp <= rows[i].w;
			seta(rows[i].a, rows[i].s);
			tx(rows[i].d, 1'b1);
			chk({7'h0, ack}, 8'h00);
			u_fram_bus_master.stop();
			wp <= 1'b0;
			rd(rows[i].a, rows[i].s, rows[i].e);
		end
		seta(16'hffff, 3'h5);
		u_fram_bus_master.start();
		tx({DEV_TYPE_CODE, 3'h5, 1'b1}, 1'b1);
		tx(8'hff, 1'b0);
		chk(r, 8'h81);
		tx(8'hff, 1'b1);
		chk(r, 8'ha5);
		u_fram_bus_master.start();
		tx({DEV_TYPE_CODE, 3'h2, 1'b0}, 1'b1);
		chk({7'h0, ack}, 8'h01);
		u_fram_bus_master.start();
		tx({4'h5, 3'h5, 1'b0}, 1'b1);
		chk({7'h0, ack}, 8'h01);
		u_fram_bus_master.start();
		tx({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
		tx(8'h00, 1'b1);
		rd(16'hffff, 3'h5, 8'h81);
		seta(16'h1234, 3'h5);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({6'h0, o_sda_oe_n, o_selected}, 8'h02);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		rd(16'h1234, 3'h5, 8'h00);
		summarize();
	end
endmodule
